/* hw/dmc_pkg.sv */
// Package of opcodes, status codes, register offsets and reset values.
package dmc_pkg;
  localparam logic [7:0] OP_UF_FIRST = 8'h40;
  localparam logic [7:0] OP_UF_LAST = 8'h47;
  localparam logic [7:0] OP_STOP = 8'h80;
  localparam logic [7:0] OP_RUN = 8'h81;
  localparam logic [7:0] OP_STEP = 8'h82;
  localparam logic [7:0] OP_RESET = 8'h83;
  localparam logic [7:0] OP_DL_ENTER = 8'h84;
  localparam logic [7:0] OP_DL_EXIT = 8'h85;
  localparam logic [7:0] OP_MEM_READ = 8'h86;
  localparam logic [7:0] OP_STATUS = 8'h87;
  localparam logic [7:0] OP_VERSION = 8'h88;
  localparam logic [7:0] OP_RESTORE = 8'h89;
  localparam logic [7:0] OP_POS_REQ = 8'h8a;
  localparam logic [7:0] OP_SW_RESET = 8'hff;
  localparam logic [7:0] OP_MOVE = 8'h04;
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_REACHED = 8'h80;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [31:0] KEY_VALUE = 32'h0000_04d2;
  localparam logic [7:0] FW_VERSION_BIN = 8'h01;
  localparam logic [7:0] FW_STRING_TAG = 8'h56;
  localparam int PROG_DEPTH = 256;
  localparam logic [11:0] OFF_CMD_LO = 12'h000;
  localparam logic [11:0] OFF_CMD_HI = 12'h004;
  localparam logic [11:0] OFF_CMD_GO = 12'h008;
  localparam logic [11:0] OFF_RPL_LO = 12'h00c;
  localparam logic [11:0] OFF_RPL_HI = 12'h010;
  localparam logic [11:0] OFF_STATE = 12'h014;
  localparam logic [11:0] OFF_MOTION = 12'h018;
  localparam logic [11:0] OFF_PROG = 12'h01c;
  localparam logic [11:0] OFF_ACCU = 12'h020;
  localparam logic [11:0] OFF_INDEX = 12'h024;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {
    DMC_HALT,
    DMC_RUN,
    DMC_STEP
  } dmc_run_t;
endpackage

/* hw/dmc_handler.sv */
// Direct-mode command handler with an APB window for frames and state.
`timescale 1ns/1ps
module dmc_handler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pos_reached_pin,
  input wire logic instr_done,
  output logic reply_valid,
  output logic [63:0] reply_frame,
  output logic move_start,
  output logic [31:0] move_target,
  output logic [1:0] run_state,
  output logic [7:0] prog_counter,
  output logic restore_pulse,
  output logic soft_reset_pulse
);
  import dmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] cmd_lo_reg;
  logic [31:0] cmd_hi_reg;
  logic go;
  logic [7:0] op;
  logic [7:0] typ;
  logic [31:0] val;
  logic [63:0] mem_word;
  logic [63:0] prog_mem [PROG_DEPTH];
  logic dl_reg;
  logic [7:0] mem_ptr_reg;
  logic [7:0] sp_reg;
  logic [31:0] accu_reg;
  logic [31:0] index_reg;
  logic [7:0] flags_reg;
  logic arm_reg;
  logic arm_keep_reg;
  logic [7:0] mask_reg;
  logic wait_reach_reg;
  logic reach_s1_reg;
  logic reach_s2_reg;
  logic reach_d_reg;
  logic done_s1_reg;
  logic done_s2_reg;
  logic reach_rise;
  logic is_ctrl;
  logic key_ok;
  logic apb_wr;
  logic [63:0] imm_frame;
  logic imm_send;
  dmc_run_t run_reg;

  // Decoding used by several processes.
  function automatic logic ctrl_op(input logic [7:0] o);
    return (o >= OP_STOP && o <= OP_POS_REQ) || o == OP_SW_RESET;
  endfunction

  function automatic logic [63:0] frame(input logic [7:0] st,
                                        input logic [7:0] cm,
                                        input logic [31:0] v);
    return {16'h0000, st, cm, v};
  endfunction

  assign apb_wr = psel && penable && pwrite;
  assign go = apb_wr && paddr == OFF_CMD_GO;
  assign op = cmd_hi_reg[7:0];
  assign typ = cmd_hi_reg[15:8];
  assign val = cmd_lo_reg;
  assign is_ctrl = ctrl_op(op);
  assign key_ok = val == KEY_VALUE;
  assign mem_word = prog_mem[val[7:0]];

  ////////////////////////////////////////////////////////////////////////
  // APB slave: zero-wait, unmapped reads return zero with an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_lo_reg <= RESET_WORD;
      cmd_hi_reg <= RESET_WORD;
    end else if (apb_wr && paddr == OFF_CMD_LO) begin
      cmd_lo_reg <= pwdata;
    end else if (apb_wr && paddr == OFF_CMD_HI) begin
      cmd_hi_reg <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RESET_WORD;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= RESET_WORD;
        case (paddr)
          OFF_CMD_LO: prdata <= cmd_lo_reg;
          OFF_CMD_HI: prdata <= cmd_hi_reg;
          OFF_CMD_GO: prdata <= RESET_WORD;
          OFF_RPL_LO: prdata <= reply_frame[31:0];
          OFF_RPL_HI: prdata <= reply_frame[63:32];
          OFF_STATE: prdata <= {22'h0, arm_keep_reg, arm_reg,
            dl_reg, wait_reach_reg, run_reg, 2'h0, reach_s2_reg, 1'b0};
          OFF_MOTION: prdata <= {24'h0, mask_reg};
          OFF_PROG: prdata <= {8'h0, flags_reg, sp_reg, prog_counter};
          OFF_ACCU: prdata <= accu_reg;
          OFF_INDEX: prdata <= index_reg;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // The link itself is the APB command window, so every command arrives
  // directly from the host; stored programs never reach this decoder.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reach_s1_reg <= 1'b0;
      reach_s2_reg <= 1'b0;
      reach_d_reg <= 1'b0;
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
    end else begin
      reach_s1_reg <= pos_reached_pin;
      reach_s2_reg <= reach_s1_reg;
      reach_d_reg <= reach_s2_reg;
      done_s1_reg <= instr_done;
      done_s2_reg <= done_s1_reg;
    end
  end
  assign reach_rise = reach_s2_reg && !reach_d_reg;

  // Download mode and program memory writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dl_reg <= 1'b0;
      mem_ptr_reg <= 8'h00;
    end else if (go) begin
      if (op == OP_DL_ENTER) begin
        dl_reg <= 1'b1;
        mem_ptr_reg <= val[7:0];
      end else if (op == OP_DL_EXIT) begin
        dl_reg <= 1'b0;
      end else if (dl_reg && !is_ctrl) begin
        mem_ptr_reg <= mem_ptr_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (go && dl_reg && !is_ctrl) begin
      prog_mem[mem_ptr_reg] <= {cmd_hi_reg, cmd_lo_reg};
    end
  end

  // Program sequencing state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= DMC_HALT;
      prog_counter <= 8'h00;
      sp_reg <= 8'h00;
      accu_reg <= RESET_WORD;
      index_reg <= RESET_WORD;
      flags_reg <= 8'h00;
    end else if (go) begin
      case (op)
        OP_STOP: run_reg <= DMC_HALT;
        OP_RUN: begin
          run_reg <= DMC_RUN;
          if (typ == 8'h01) begin
            prog_counter <= val[7:0];
          end
        end
        OP_STEP: run_reg <= DMC_STEP;
        OP_RESET: begin
          run_reg <= DMC_HALT;
          prog_counter <= 8'h00;
          sp_reg <= 8'h00;
          accu_reg <= RESET_WORD;
          index_reg <= RESET_WORD;
          flags_reg <= 8'h00;
        end
        default: begin
        end
      endcase
    end else if (done_s2_reg && run_reg != DMC_HALT) begin
      prog_counter <= prog_counter + 8'h01;
      if (run_reg == DMC_STEP) begin
        run_reg <= DMC_HALT;
      end
    end
  end
  assign run_state = run_reg;

  // Position-reached arming and motion launch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_reg <= 1'b0;
      arm_keep_reg <= 1'b0;
      mask_reg <= 8'h00;
      wait_reach_reg <= 1'b0;
      move_start <= 1'b0;
      move_target <= RESET_WORD;
    end else begin
      move_start <= 1'b0;
      if (go && op == OP_POS_REQ) begin
        arm_reg <= 1'b1;
        arm_keep_reg <= typ == 8'h01;
        mask_reg <= val[7:0];
      end else if (go && op == OP_MOVE && !dl_reg) begin
        move_start <= 1'b1;
        move_target <= val;
        wait_reach_reg <= arm_reg;
        if (!arm_keep_reg) begin
          arm_reg <= 1'b0;
        end
      end else if (reach_rise && wait_reach_reg && !imm_send) begin
        wait_reach_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Immediate reply frame for the command being executed.
  always_comb begin
    imm_send = 1'b0;
    imm_frame = frame(ST_OK, op, RESET_WORD);
    if (go) begin
      imm_send = 1'b1;
      if (dl_reg && !is_ctrl) begin
        imm_frame = frame(ST_OK, op, {24'h0, mem_ptr_reg});
      end else if (op >= OP_UF_FIRST && op <= OP_UF_LAST) begin
        imm_frame = frame(ST_OK, op, RESET_WORD);
      end else if (op == OP_POS_REQ) begin
        imm_frame = frame(ST_OK, OP_POS_REQ, {24'h0, val[7:0]});
      end else if (op == OP_MEM_READ) begin
        imm_frame = mem_word;
      end else if (op == OP_STATUS) begin
        case (typ)
          8'h00: imm_frame = frame(ST_OK, op, {8'h0, 6'h0, run_reg,
            7'h0, wait_reach_reg, mem_ptr_reg});
          8'h01: imm_frame = frame(ST_OK, op, {8'h0, 6'h0, run_reg,
            7'h0, wait_reach_reg, prog_counter});
          8'h02: imm_frame = frame(ST_OK, op, accu_reg);
          8'h03: imm_frame = frame(ST_OK, op, index_reg);
          default: imm_frame = frame(ST_BAD_CMD, op, RESET_WORD);
        endcase
      end else if (op == OP_VERSION) begin
        imm_frame = typ == 8'h00 ?
          {8'h0, FW_STRING_TAG, 40'h0, FW_VERSION_BIN} :
          frame(ST_OK, op, {24'h0, FW_VERSION_BIN});
      end else if (op == OP_RESTORE || op == OP_SW_RESET) begin
        imm_send = 1'b0;
      end
    end
  end

  // Replies: the immediate one takes priority; the deferred one stays pending until the next reached edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reply_valid <= 1'b0;
      reply_frame <= 64'h0;
    end else begin
      reply_valid <= 1'b0;
      if (imm_send) begin
        reply_valid <= 1'b1;
        reply_frame <= imm_frame;
      end else if (reach_rise && wait_reach_reg) begin
        reply_valid <= 1'b1;
        reply_frame <= frame(ST_REACHED, OP_POS_REQ,
          {24'h0, mask_reg});
      end
    end
  end

  // Key-guarded restore and restart pulses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_pulse <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      restore_pulse <= go && op == OP_RESTORE && key_ok;
      soft_reset_pulse <= go && op == OP_SW_RESET && key_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // A deferred frame may land in any cycle, and a raw memory word may carry
  // any status byte, so the frame checks key on status and command both.
  a_restore_key: assert property (@(posedge pclk)
    disable iff (!presetn)
    restore_pulse |-> $past(key_ok) && $past(op) == OP_RESTORE)
    else $error("restore without key");
  a_reset_key: assert property (@(posedge pclk)
    disable iff (!presetn)
    soft_reset_pulse |-> $past(key_ok) && $past(op) == OP_SW_RESET)
    else $error("soft reset without key");
  a_no_restore_reply: assert property (@(posedge pclk)
    disable iff (!presetn)
    go && op == OP_RESTORE |=> !reply_valid
    || (reply_frame[47:40] == ST_REACHED
    && reply_frame[39:32] == OP_POS_REQ))
    else $error("reply after restore");
  a_imm_reply: assert property (@(posedge pclk)
    disable iff (!presetn)
    go && op == OP_POS_REQ |=> reply_valid && reply_frame[47:40] == ST_OK
    && reply_frame[39:32] == OP_POS_REQ
    && reply_frame[31:0] == {24'h0, mask_reg})
    else $error("bad immediate reply");
  a_late_reply: assert property (@(posedge pclk)
    disable iff (!presetn)
    reply_valid && reply_frame[47:40] == ST_REACHED
    && reply_frame[39:32] == OP_POS_REQ
    |-> reply_frame[31:8] == 24'h0 && reply_frame[7:0] == mask_reg)
    else $error("bad deferred reply");
  a_late_once: assert property (@(posedge pclk)
    disable iff (!presetn)
    reply_valid && reply_frame[47:40] == ST_REACHED
    && reply_frame[39:32] == OP_POS_REQ |-> !wait_reach_reg)
    else $error("deferred reply left pending");
  a_one_shot: assert property (@(posedge pclk)
    disable iff (!presetn)
    go && op == OP_MOVE && !dl_reg && !arm_keep_reg |=> !arm_reg)
    else $error("single arm not cleared");
  a_keep_arm: assert property (@(posedge pclk)
    disable iff (!presetn)
    go && op == OP_MOVE && !dl_reg && arm_keep_reg && arm_reg
    |=> arm_reg && wait_reach_reg)
    else $error("persistent arm lost");
  a_step_halt: assert property (@(posedge pclk)
    disable iff (!presetn)
    run_reg == DMC_STEP && done_s2_reg && !go |=> run_reg == DMC_HALT)
    else $error("step did not halt");
  a_reset_clear: assert property (@(posedge pclk)
    disable iff (!presetn)
    go && op == OP_RESET |=> prog_counter == 8'h00 && accu_reg == 32'h0
    && run_reg == DMC_HALT)
    else $error("reset did not clear");
  a_download: assert property (@(posedge pclk)
    disable iff (!presetn)
    go && op == OP_DL_ENTER |=> dl_reg ##0 mem_ptr_reg == $past(val[7:0]))
    else $error("download not entered");
  a_dl_no_move: assert property (@(posedge pclk)
    disable iff (!presetn)
    go && op == OP_MOVE && dl_reg |=> !move_start)
    else $error("stored move was started");
  c_late: cover property (@(posedge pclk)
    reply_valid && reply_frame[47:40] == ST_REACHED);
  c_download: cover property (@(posedge pclk) go && dl_reg && !is_ctrl);
  c_restart: cover property (@(posedge pclk) soft_reset_pulse);
  c_keep_move: cover property (@(posedge pclk)
    go && op == OP_MOVE && arm_keep_reg);
  c_step: cover property (@(posedge pclk) run_reg == DMC_STEP && done_s2_reg);
endmodule

/* dv/dmc_motor_model.sv */
// Model of the motor and program engine that face the command handler.
`timescale 1ns/1ps
module dmc_motor_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic move_start,
  input wire logic [1:0] run_state,
  output logic pos_reached_pin,
  output logic instr_done
);
  import dmc_pkg::*;
  logic [2:0] trav_reg;
  logic [2:0] cnt_reg;
  ////////////////////////////////////////////////////////////////////////////
  // The pin drops as a move starts and rises later, so that every
  // completion shows as a fresh rising edge and none is missed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trav_reg <= 3'h0;
      pos_reached_pin <= 1'b0;
    end else if (move_start === 1'b1) begin
      trav_reg <= 3'h6;
      pos_reached_pin <= 1'b0;
    end else if (trav_reg != 3'h0) begin
      trav_reg <= trav_reg - 3'h1;
      pos_reached_pin <= (trav_reg == 3'h1);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // One instruction completes a few cycles after the engine leaves halt.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 3'h0;
      instr_done <= 1'b0;
    end else begin
      cnt_reg <= (run_state == DMC_HALT) ? 3'h0 : cnt_reg + 3'h1;
      instr_done <= (cnt_reg == 3'h3);
    end
  end
endmodule

/* dv/tb_direct_mode_control_command_handler.sv */
// Self-checking testbench of the direct-mode command handler.
`timescale 1ns/1ps
module tb_direct_mode_control_command_handler;
  import dmc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pos_reached_pin, instr_done, reply_valid;
  logic [63:0] reply_frame, last_frame;
  logic move_start, restore_pulse, soft_reset_pulse;
  logic [31:0] move_target, rd;
  logic [1:0] run_state;
  logic [7:0] prog_counter;
  logic err;
  int miscompares = 0;
  int num_checks = 0;
  int nrep = 0;
  int nrest = 0;
  int nsoft = 0;
  int base = 0;
  ////////////////////////////////////////////////////////////////////////////
  dmc_handler dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pos_reached_pin(pos_reached_pin), .instr_done(instr_done),
    .reply_valid(reply_valid), .reply_frame(reply_frame),
    .move_start(move_start), .move_target(move_target),
    .run_state(run_state), .prog_counter(prog_counter),
    .restore_pulse(restore_pulse), .soft_reset_pulse(soft_reset_pulse));
  dmc_motor_model motor_u (.pclk(pclk), .presetn(presetn),
    .move_start(move_start), .run_state(run_state),
    .pos_reached_pin(pos_reached_pin), .instr_done(instr_done));
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // Replies last one cycle, so they are counted at every edge.
  always @(posedge pclk) begin
    if (reply_valid === 1'b1) begin
      nrep <= nrep + 1;
      last_frame <= reply_frame;
    end
    if (restore_pulse === 1'b1) nrest <= nrest + 1;
    if (soft_reset_pulse === 1'b1) nsoft <= nsoft + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
                     input string msg);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // The motor field is left zero and only the single-motor mask is used.
  task automatic cmd(input logic [7:0] op, input logic [7:0] ty,
                     input logic [31:0] v);
    base = nrep;
    apb(1'b1, OFF_CMD_LO, v);
    apb(1'b1, OFF_CMD_HI, {16'h0, ty, op});
    apb(1'b1, OFF_CMD_GO, 32'h1);
    idle(3);
  endtask
  task automatic rep(input logic [7:0] st, input logic [7:0] op,
                     input logic [31:0] v);
    chk(last_frame, {16'h0, st, op, v}, "reply frame");
  endtask
  task automatic nreps(input int n);
    chk(64'(nrep - base), 64'(n), "reply count");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    idle(20000);
    miscompares++;
    complete_run;
  end
  initial begin
    idle(3);
    presetn <= 1'b1;
    for (int i = 5; i < 10; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(64'(rd), 64'(RESET_WORD), "reset value");
    end
    apb(1'b0, 12'h100, 32'h0);
    chk(64'(err), 64'h1, "unmapped access");
    $display("test registers done");
    for (int op = 64; op < 72; op++) begin
      cmd(8'(op), 8'h00, 32'h0);
      nreps(1);
      chk(64'(last_frame[47:32]), 64'({ST_OK, 8'(op)}), "user fn");
    end
    $display("test user functions done");
    cmd(OP_POS_REQ, 8'h00, 32'h1);
    nreps(1);
    rep(ST_OK, OP_POS_REQ, 32'h1);
    apb(1'b0, OFF_MOTION, 32'h0);
    chk(64'(rd), 64'h1, "armed mask");
    cmd(OP_MOVE, 8'h00, 32'h100);
    chk(64'(move_target), 64'h100, "move target");
    idle(16);
    nreps(2);
    rep(ST_REACHED, OP_POS_REQ, 32'h1);
    cmd(OP_MOVE, 8'h00, 32'h200);
    idle(16);
    nreps(1);
    cmd(OP_POS_REQ, 8'h01, 32'h1);
    for (int i = 0; i < 2; i++) begin
      cmd(OP_MOVE, 8'h00, 32'h300);
      idle(16);
      nreps(2);
      rep(ST_REACHED, OP_POS_REQ, 32'h1);
    end
    $display("test position reached done");
    cmd(OP_RUN, 8'h01, 32'h5);
    chk(64'({run_state, prog_counter}), 64'({2'd1, 8'h05}), "run");
    cmd(OP_STOP, 8'h00, 32'h0);
    chk(64'(run_state), 64'(DMC_HALT), "stop");
    cmd(OP_RESET, 8'h00, 32'h0);
    chk(64'(prog_counter), 64'h0, "reset counter");
    apb(1'b0, OFF_ACCU, 32'h0);
    chk(64'(rd), 64'h0, "reset accumulator");
    cmd(OP_STEP, 8'h00, 32'h0);
    idle(12);
    chk(64'({run_state, prog_counter}), 64'({2'd0, 8'h01}), "step");
    cmd(OP_STATUS, 8'h01, 32'h0);
    chk(64'(last_frame[7:0]), 64'h01, "status counter");
    cmd(OP_STATUS, 8'h02, 32'h0);
    rep(ST_OK, OP_STATUS, 32'h0);
    cmd(OP_STATUS, 8'h03, 32'h0);
    rep(ST_OK, OP_STATUS, 32'h0);
    cmd(OP_RUN, 8'h00, 32'h77);
    chk(64'({run_state, prog_counter}), 64'h101, "resume");
    cmd(OP_STOP, 8'h00, 32'h0);
    chk(64'(run_state), 64'(DMC_HALT), "stop again");
    cmd(OP_STATUS, 8'h04, 32'h0);
    chk(64'(last_frame[47:40]), 64'(ST_BAD_CMD), "bad status");
    $display("test program control done");
    cmd(OP_DL_ENTER, 8'h00, 32'ha);
    apb(1'b0, OFF_STATE, 32'h0);
    chk(64'(rd[7]), 64'h1, "download on");
    cmd(OP_UF_FIRST, 8'h00, 32'h1234_5678);
    rep(ST_OK, OP_UF_FIRST, 32'ha);
    cmd(OP_MOVE, 8'h00, 32'h999);
    chk(64'(move_target), 64'h300, "stored move");
    cmd(OP_STATUS, 8'h00, 32'h0);
    chk(64'(last_frame[7:0]), 64'h0c, "status pointer");
    cmd(OP_DL_EXIT, 8'h00, 32'h0);
    apb(1'b0, OFF_STATE, 32'h0);
    chk(64'(rd[7]), 64'h0, "download off");
    cmd(OP_MEM_READ, 8'h00, 32'ha);
    chk(64'(last_frame[31:0]), 64'h1234_5678, "memory word");
    cmd(OP_VERSION, 8'h01, 32'h0);
    chk(64'(last_frame[7:0]), 64'(FW_VERSION_BIN), "version");
    cmd(OP_VERSION, 8'h00, 32'h0);
    nreps(1);
    chk(64'(last_frame[55:48]), 64'(FW_STRING_TAG), "version tag");
    $display("test download and queries done");
    cmd(OP_RESTORE, 8'h00, 32'd1233);
    cmd(OP_SW_RESET, 8'h00, 32'd1233);
    chk(64'({nrest, nsoft}), 64'h0, "wrong key");
    cmd(OP_RESTORE, 8'h00, KEY_VALUE);
    nreps(0);
    cmd(OP_SW_RESET, 8'h00, KEY_VALUE);
    nreps(0);
    chk(64'({nrest, nsoft}), {32'd1, 32'd1}, "key pulses");
    $display("test keyed commands done");
    complete_run;
  end
endmodule
